// ==== cscr_regs.sv ====
// CPU status and core control register pair with DSP-side status inputs.
// Assumes a single clock; the core reports loop and accumulator events.
// Functional notes
// - Software may read or clear the combined saturation flag, never set it, and clearing it clears both per-accumulator flags.
// - The loop-active bit is 1 while a hardware loop runs and 0 otherwise.
// - The sign control bit selects unsigned multiplies when 1 and signed when 0.
// - Writing 1 to the early terminate bit ends the running loop at the end of its iteration; 0 does nothing.
// - The early terminate bit always reads as 0.
// - The nesting depth field is read-only and reports 0 to 7 active loops in binary.
// - Each accumulator has a saturation enable that turns saturation on when 1.
// - Program memory is mapped into data space only while the visibility bit is 1.
// - The multiplier mode bit selects integer when 1 and fractional when 0.
// - The priority level joins the three low bits of status with the high bit of control.
// - While the priority high bit is 1 all user interrupts are disabled.
// - The three low priority bits are read-only while nesting disable is 1.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module cscr_regs
    import cscr_pkg::*;
#(
    parameter int DW = cscr_pkg::DATA_W,
    parameter int AW = cscr_pkg::ADDR_W
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DW-1:0] reg_rdata,
    input wire logic acc_a_overflow_in,
    input wire logic acc_b_overflow_in,
    input wire logic acc_a_saturate_evt,
    input wire logic acc_b_saturate_evt,
    input wire logic loop_running,
    input wire logic [cscr_pkg::NEST_W-1:0] loop_depth_in,
    input wire logic loop_iteration_end,
    input wire logic [cscr_pkg::ALU_W-1:0] alu_flags_in,
    input wire logic alu_flags_we,
    input wire logic digit_carry_in,
    input wire logic nesting_disable_control,
    input wire logic [2:0] core_priority_in,
    input wire logic core_priority_we,
    output logic multiply_sign_select,
    output logic multiply_integer_mode,
    output logic acc_a_saturation_enable,
    output logic acc_b_saturation_enable,
    output logic data_write_saturation_enable,
    output logic super_saturation_mode,
    output logic rounding_mode,
    output logic program_space_visibility,
    output logic loop_terminate_req,
    output logic [3:0] cpu_priority_level,
    output logic user_irq_enable,
    output logic irq
);
    import cscr_pkg::*;

    // Status state
    logic acc_a_overflow_flag;
    logic acc_b_overflow_flag;
    logic acc_a_saturated_flag;
    logic acc_b_saturated_flag;
    logic loop_active_flag;
    logic [NEST_W-1:0] loop_nesting_depth;
    logic digit_carry_reg;
    logic [2:0] priority_low_bits;
    logic [ALU_W-1:0] alu_flags_reg;
    // Control state
    logic [DW-1:0] ctrl_reg;
    logic priority_high_bit;
    cscr_term_e term_state_reg;
    cscr_term_e term_state_next;
    // Decode
    logic wr_status;
    logic wr_ctrl;
    logic wr_evstat;
    logic wr_evmask;
    logic sat_ab_clear;
    logic combined_saturation_flag;
    logic combined_overflow_flag;
    logic [EV_W-1:0] ev_set;
    logic [EV_W-1:0] ev_clear;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic sat_a_clear;
    logic sat_b_clear;
    logic [DW-1:0] status_word;
    logic [DW-1:0] control_word;

    function automatic logic addr_hit(input logic [AW-1:0] a, input logic [3:0] r);
        addr_hit = (a == AW'(r));
    endfunction : addr_hit

    assign wr_status = reg_write && addr_hit(reg_addr, ADDR_CPU_STATUS);
    assign wr_ctrl = reg_write && addr_hit(reg_addr, ADDR_CORE_CONTROL);
    assign wr_evstat = reg_write && addr_hit(reg_addr, ADDR_EVENT_STATUS);
    assign wr_evmask = reg_write && addr_hit(reg_addr, ADDR_EVENT_MASK);

    // Software write of 0 to combined saturation bit clears; 1 has no effect
    assign sat_ab_clear = wr_status && !reg_wdata[ST_SAT_AB];

    // Per-accumulator clear: own bit or combined bit written 0
    assign sat_a_clear = sat_ab_clear || (wr_status && !reg_wdata[ST_SAT_A]);
    assign sat_b_clear = sat_ab_clear || (wr_status && !reg_wdata[ST_SAT_B]);

    // Combined flags are derived, never stored
    assign combined_saturation_flag = acc_a_saturated_flag | acc_b_saturated_flag;
    assign combined_overflow_flag = acc_a_overflow_flag | acc_b_overflow_flag;

    // Overflow flag A follows the DSP engine
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_a_overflow_flag <= 1'b0;
        end else begin
            acc_a_overflow_flag <= acc_a_overflow_in;
        end
    end

    // Overflow flag B follows the DSP engine
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_b_overflow_flag <= 1'b0;
        end else begin
            acc_b_overflow_flag <= acc_b_overflow_in;
        end
    end

    // Sticky saturation flag A; engine event wins over software clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_a_saturated_flag <= 1'b0;
        end else if (acc_a_saturate_evt) begin
            acc_a_saturated_flag <= 1'b1;
        end else if (sat_a_clear) begin
            acc_a_saturated_flag <= 1'b0;
        end
    end

    // Sticky saturation flag B; same priority as flag A
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acc_b_saturated_flag <= 1'b0;
        end else if (acc_b_saturate_evt) begin
            acc_b_saturated_flag <= 1'b1;
        end else if (sat_b_clear) begin
            acc_b_saturated_flag <= 1'b0;
        end
    end

    // Loop-active bit mirrors the loop engine
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loop_active_flag <= 1'b0;
        end else begin
            loop_active_flag <= loop_running;
        end
    end

    // Nesting depth mirrors the loop engine
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loop_nesting_depth <= '0;
        end else begin
            loop_nesting_depth <= loop_depth_in;
        end
    end

    // Priority low bits: core update has priority, software only when allowed
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            priority_low_bits <= 3'h0;
        end else if (core_priority_we) begin
            priority_low_bits <= core_priority_in;
        end else if (wr_status && !nesting_disable_control) begin
            priority_low_bits <= reg_wdata[ST_PRI_LO +: 3];
        end
    end

    // Digit carry, core update beats software
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            digit_carry_reg <= 1'b0;
        end else if (alu_flags_we) begin
            digit_carry_reg <= digit_carry_in;
        end else if (wr_status) begin
            digit_carry_reg <= reg_wdata[ST_DC];
        end
    end

    // ALU flags, core update beats software
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            alu_flags_reg <= '0;
        end else if (alu_flags_we) begin
            alu_flags_reg <= alu_flags_in;
        end else if (wr_status) begin
            alu_flags_reg <= reg_wdata[ST_ALU_LO +: ALU_W];
        end
    end

    // Core control bits; early terminate and depth not stored here
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CORE_CONTROL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg[CC_SIGN] <= reg_wdata[CC_SIGN];
            ctrl_reg[CC_SAT_A] <= reg_wdata[CC_SAT_A];
            ctrl_reg[CC_SAT_B] <= reg_wdata[CC_SAT_B];
            ctrl_reg[CC_SAT_DW] <= reg_wdata[CC_SAT_DW];
            ctrl_reg[CC_ACCSAT] <= reg_wdata[CC_ACCSAT];
            ctrl_reg[CC_PSV] <= reg_wdata[CC_PSV];
            ctrl_reg[CC_RND] <= reg_wdata[CC_RND];
            ctrl_reg[CC_INT] <= reg_wdata[CC_INT];
        end
    end

    // Priority high bit: software may only clear it, as marked clear-only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            priority_high_bit <= 1'b0;
        end else if (wr_ctrl && !reg_wdata[CC_PRI_HI]) begin
            priority_high_bit <= 1'b0;
        end
    end

    // Early terminate sequencer: arm on write of 1, fire at iteration end
    always_comb begin
        term_state_next = term_state_reg;
        case (term_state_reg)
            CSCR_IDLE: begin
                if (wr_ctrl && reg_wdata[CC_EARLY] && loop_running) begin
                    term_state_next = CSCR_ARMED;
                end
            end
            CSCR_ARMED: begin
                // Iteration end first: the engine may drop running on that edge
                if (loop_iteration_end) begin
                    term_state_next = CSCR_DONE;
                end else if (!loop_running) begin
                    term_state_next = CSCR_IDLE;
                end
            end
            CSCR_DONE: begin
                term_state_next = CSCR_IDLE;
            end
            default: begin
                term_state_next = CSCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            term_state_reg <= CSCR_IDLE;
        end else begin
            term_state_reg <= term_state_next;
        end
    end

    // Terminate request held while armed, so engine ends at iteration end
    assign loop_terminate_req = (term_state_reg == CSCR_ARMED);

    // Control outputs
    assign multiply_sign_select = ctrl_reg[CC_SIGN];
    assign multiply_integer_mode = ctrl_reg[CC_INT];
    assign acc_a_saturation_enable = ctrl_reg[CC_SAT_A];
    assign acc_b_saturation_enable = ctrl_reg[CC_SAT_B];
    assign data_write_saturation_enable = ctrl_reg[CC_SAT_DW];
    assign super_saturation_mode = ctrl_reg[CC_ACCSAT];
    assign rounding_mode = ctrl_reg[CC_RND];
    assign program_space_visibility = ctrl_reg[CC_PSV];
    assign cpu_priority_level = {priority_high_bit, priority_low_bits};
    assign user_irq_enable = !priority_high_bit;

    // Events: saturation, overflow rises, loop terminated
    assign ev_set = {term_state_reg == CSCR_DONE,
                     acc_b_overflow_in & ~acc_b_overflow_flag,
                     acc_a_overflow_in & ~acc_a_overflow_flag,
                     acc_b_saturate_evt, acc_a_saturate_evt};
    assign ev_clear = wr_evstat ? reg_wdata[EV_W-1:0] : '0;

    cscr_event_regs #(
        .W(EV_W)
    ) u_events (
        .clock(clock),
        .rst_n(rst_n),
        .event_set(ev_set),
        .clear_mask(ev_clear),
        .mask_we(wr_evmask),
        .mask_wdata(reg_wdata[EV_W-1:0]),
        .status_reg(ev_status),
        .mask_reg(ev_mask),
        .irq(irq)
    );

    // Status word as software reads it, field by field
    always_comb begin
        status_word = '0;
        status_word[ST_OVF_A] = acc_a_overflow_flag;
        status_word[ST_OVF_B] = acc_b_overflow_flag;
        status_word[ST_SAT_A] = acc_a_saturated_flag;
        status_word[ST_SAT_B] = acc_b_saturated_flag;
        status_word[ST_OVF_AB] = combined_overflow_flag;
        status_word[ST_SAT_AB] = combined_saturation_flag;
        status_word[ST_LOOP] = loop_active_flag;
        status_word[ST_DC] = digit_carry_reg;
        status_word[ST_PRI_LO +: 3] = priority_low_bits;
        status_word[ST_ALU_LO +: ALU_W] = alu_flags_reg;
    end

    // Control word; early terminate bit stays 0, depth is live status
    always_comb begin
        control_word = '0;
        control_word[CC_SIGN] = ctrl_reg[CC_SIGN];
        control_word[CC_NEST +: NEST_W] = loop_nesting_depth;
        control_word[CC_SAT_A] = ctrl_reg[CC_SAT_A];
        control_word[CC_SAT_B] = ctrl_reg[CC_SAT_B];
        control_word[CC_SAT_DW] = ctrl_reg[CC_SAT_DW];
        control_word[CC_ACCSAT] = ctrl_reg[CC_ACCSAT];
        control_word[CC_PRI_HI] = priority_high_bit;
        control_word[CC_PSV] = ctrl_reg[CC_PSV];
        control_word[CC_RND] = ctrl_reg[CC_RND];
        control_word[CC_INT] = ctrl_reg[CC_INT];
    end

    // Read data, registered, one cycle after the read strobe
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                AW'(ADDR_CPU_STATUS): begin
                    reg_rdata <= status_word;
                end
                AW'(ADDR_CORE_CONTROL): begin
                    reg_rdata <= control_word;
                end
                AW'(ADDR_EVENT_STATUS): begin
                    reg_rdata <= {{(DW-EV_W){1'b0}}, ev_status};
                end
                AW'(ADDR_EVENT_MASK): begin
                    reg_rdata <= {{(DW-EV_W){1'b0}}, ev_mask};
                end
                default: begin
                    reg_rdata <= '0;
                end
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end
endmodule : cscr_regs

// ==== cscr_pkg.sv ====
// Package for the CPU status and core control register pair.
// Assumes a 16-bit register port with four word addresses.
package cscr_pkg;
    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int NEST_W = 3;
    // Register addresses
    localparam logic [3:0] ADDR_CPU_STATUS = 4'h0;
    localparam logic [3:0] ADDR_CORE_CONTROL = 4'h1;
    localparam logic [3:0] ADDR_EVENT_STATUS = 4'h2;
    localparam logic [3:0] ADDR_EVENT_MASK = 4'h3;
    // Status register fields
    localparam int ST_OVF_A = 15;
    localparam int ST_OVF_B = 14;
    localparam int ST_SAT_A = 13;
    localparam int ST_SAT_B = 12;
    localparam int ST_OVF_AB = 11;
    localparam int ST_SAT_AB = 10;
    localparam int ST_LOOP = 9;
    localparam int ST_DC = 8;
    localparam int ST_PRI_LO = 5;
    localparam int ST_ALU_LO = 0;
    localparam int ALU_W = 5;
    // Core control fields
    localparam int CC_SIGN = 12;
    localparam int CC_EARLY = 11;
    localparam int CC_NEST = 8;
    localparam int CC_SAT_A = 7;
    localparam int CC_SAT_B = 6;
    localparam int CC_SAT_DW = 5;
    localparam int CC_ACCSAT = 4;
    localparam int CC_PRI_HI = 3;
    localparam int CC_PSV = 2;
    localparam int CC_RND = 1;
    localparam int CC_INT = 0;
    // Reset values
    localparam logic [15:0] CPU_STATUS_RST = 16'h0000;
    localparam logic [15:0] CORE_CONTROL_RST = 16'h0020;
    // Event bits: sat A, sat B, ovf A, ovf B, early terminate done
    localparam int EV_W = 5;
    localparam logic [4:0] EV_RST = 5'h00;
    // Early-terminate sequencer states
    typedef enum logic [1:0] {
        CSCR_IDLE = 2'b00,
        CSCR_ARMED = 2'b01,
        CSCR_DONE = 2'b11
    } cscr_term_e;
endpackage : cscr_pkg

// ==== cscr_event_regs.sv ====
// Sticky event status with mask and a level interrupt output.
// Assumes write-one-to-clear from the register port.
`timescale 1ns/1ps
module cscr_event_regs #(
    parameter int W = 5
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] event_set,
    input wire logic [W-1:0] clear_mask,
    input wire logic mask_we,
    input wire logic [W-1:0] mask_wdata,
    output logic [W-1:0] status_reg,
    output logic [W-1:0] mask_reg,
    output logic irq
);
    // Sticky status, set wins over clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= '0;
        end else begin
            status_reg <= (status_reg & ~clear_mask) | event_set;
        end
    end
    // Mask register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= '0;
        end else if (mask_we) begin
            mask_reg <= mask_wdata;
        end
    end
    // Level interrupt
    assign irq = |(status_reg & mask_reg);
endmodule : cscr_event_regs

// ==== cscr_regs_monitor.sv ====
// Port checker for the status and core control pair.
// Assumes one clock and the register addresses of the package.
`timescale 1ns/1ps
module cscr_regs_monitor
    import cscr_pkg::*;
#(
    parameter int DW = 16,
    parameter int AW = 4
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [AW-1:0] reg_addr,
    input wire logic [DW-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [DW-1:0] reg_rdata,
    input wire logic loop_running,
    input wire logic loop_iteration_end,
    input wire logic nesting_disable_control,
    input wire logic core_priority_we,
    input wire logic multiply_sign_select,
    input wire logic multiply_integer_mode,
    input wire logic acc_a_saturation_enable,
    input wire logic acc_b_saturation_enable,
    input wire logic program_space_visibility,
    input wire logic loop_terminate_req,
    input wire logic [3:0] cpu_priority_level
);
    logic cc_wr;
    logic st_wr;
    // Write strobes of the two registers
    assign cc_wr = reg_write && reg_addr == ADDR_CORE_CONTROL;
    assign st_wr = reg_write && reg_addr == ADDR_CPU_STATUS && !core_priority_we;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Mode outputs follow a control write one cycle later
    property p_sign; cc_wr |=> multiply_sign_select == $past(reg_wdata[CC_SIGN]); endproperty
    a_sign: assert property (p_sign) else $error("sign mode wrong");
    property p_int; cc_wr |=> multiply_integer_mode == $past(reg_wdata[CC_INT]); endproperty
    a_int: assert property (p_int) else $error("integer mode wrong");
    property p_sat; cc_wr |=> {acc_a_saturation_enable, acc_b_saturation_enable}
        == $past(reg_wdata[CC_SAT_B+:2]); endproperty
    a_sat: assert property (p_sat) else $error("saturation enable wrong");
    property p_psv; cc_wr |=> program_space_visibility == $past(reg_wdata[CC_PSV]); endproperty
    a_psv: assert property (p_psv) else $error("visibility wrong");
    // Low priority bits follow status writes unless locked
    property p_pri; st_wr && !nesting_disable_control |=> cpu_priority_level[2:0]
        == $past(reg_wdata[ST_PRI_LO+:3]); endproperty
    a_pri: assert property (p_pri) else $error("priority level wrong");
    property p_lock; st_wr && nesting_disable_control |=> $stable(cpu_priority_level);
    endproperty
    a_lock: assert property (p_lock) else $error("locked priority changed");
    // Early exit arms on a one during a loop and drops at the iteration end
    property p_arm; cc_wr && reg_wdata[CC_EARLY] && loop_running && $past(loop_running)
        && !loop_iteration_end |=> loop_terminate_req; endproperty
    a_arm: assert property (p_arm) else $error("early exit not armed");
    property p_drop; loop_terminate_req && loop_iteration_end && !cc_wr
        |=> !loop_terminate_req; endproperty
    a_drop: assert property (p_drop) else $error("early exit not dropped");
    property p_rz; reg_read && reg_addr == ADDR_CORE_CONTROL |=> !reg_rdata[CC_EARLY];
    endproperty
    a_rz: assert property (p_rz) else $error("early exit bit read as one");
endmodule : cscr_regs_monitor

bind cscr_regs cscr_regs_monitor #(.DW(DW), .AW(AW)) i_cscr_regs_monitor (.clock, .rst_n,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .loop_running,
    .loop_iteration_end, .nesting_disable_control, .core_priority_we, .multiply_sign_select,
    .multiply_integer_mode, .acc_a_saturation_enable, .acc_b_saturation_enable,
    .program_space_visibility, .loop_terminate_req, .cpu_priority_level);

// ==== cscr_core_model.sv ====
// Model of the execution core and DSP engine side.
// Assumes the bench commands loops and accumulator events.
`timescale 1ns/1ps
module cscr_core_model (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [1:0] sat_cmd,
    input wire logic [1:0] ovf_cmd,
    input wire logic loop_terminate_req,
    output logic loop_running,
    output logic [2:0] loop_depth_in,
    output logic loop_iteration_end,
    output logic acc_a_overflow_in,
    output logic acc_b_overflow_in,
    output logic acc_a_saturate_evt,
    output logic acc_b_saturate_evt
);
    logic [3:0] left_reg;
    logic [1:0] phase_reg;
    // Three nested loops reported only while running
    assign loop_depth_in = loop_running ? 3'h3 : 3'h0;
    // Seven iterations of four cycles, early exit at an iteration end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loop_running <= 1'b0;
            loop_iteration_end <= 1'b0;
            left_reg <= 4'h0;
            phase_reg <= 2'h0;
        end else begin
            loop_iteration_end <= 1'b0;
            if (go && !loop_running) begin
                loop_running <= 1'b1;
                left_reg <= 4'h7;
                phase_reg <= 2'h0;
            end else if (loop_running) begin
                phase_reg <= phase_reg + 2'h1;
                if (phase_reg == 2'h3) begin
                    loop_iteration_end <= 1'b1;
                    left_reg <= left_reg - 4'h1;
                    if (left_reg == 4'h1 || loop_terminate_req) begin
                        loop_running <= 1'b0;
                    end
                end
            end
        end
    end
    // Accumulator levels and pulses one cycle behind the command
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {acc_a_overflow_in, acc_b_overflow_in} <= 2'h0;
            {acc_a_saturate_evt, acc_b_saturate_evt} <= 2'h0;
        end else begin
            {acc_a_overflow_in, acc_b_overflow_in} <= {ovf_cmd[0], ovf_cmd[1]};
            {acc_a_saturate_evt, acc_b_saturate_evt} <= {sat_cmd[0], sat_cmd[1]};
        end
    end
endmodule : cscr_core_model

// ==== cscr_tb.sv ====
// Bench for the status and core control pair: table, then hand cases.
// Assumes the core model stands in for the loop and accumulator side.
`timescale 1ns/1ps
module testbench;
    import cscr_pkg::*;
    localparam logic [3:0] AS = ADDR_CPU_STATUS;
    localparam logic [3:0] AC = ADDR_CORE_CONTROL;
    localparam logic [3:0] AE = ADDR_EVENT_STATUS;
    localparam logic [3:0] AM = ADDR_EVENT_MASK;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic nesting_disable_control = 1'b0;
    logic go = 1'b0;
    logic [1:0] sat_cmd = 2'h0;
    logic [1:0] ovf_cmd = 2'h0;
    logic [15:0] reg_rdata;
    logic acc_a_overflow_in, acc_b_overflow_in, acc_a_saturate_evt, acc_b_saturate_evt;
    logic loop_running, loop_iteration_end, loop_terminate_req, user_irq_enable, irq;
    logic [2:0] loop_depth_in;
    logic [3:0] cpu_priority_level;
    logic multiply_sign_select, multiply_integer_mode, super_saturation_mode, rounding_mode;
    logic acc_a_saturation_enable, acc_b_saturation_enable, data_write_saturation_enable;
    logic program_space_visibility;
    logic [8:0] modes;
    int mismatches = 0;
    int total_checks = 0;
    int cycles = 0;
    // Rows: address, write data, read back, mode outputs
    logic [3:0] r_a [8] = '{AC, AC, AC, AC, AS, AS, 4'h5, AM};
    logic [15:0] r_w [8] = '{16'h1004, 16'h08C1, 16'hFFFF, 16'h0000, 16'h04E0, 16'hFE00,
        16'hFFFF, 16'h001F};
    logic [15:0] r_r [8] = '{16'h1004, 16'h00C1, 16'h10F7, 16'h0000, 16'h00E0, 16'h0000,
        16'h0000, 16'h001F};
    logic [8:0] r_o [8] = '{9'h110, 9'h0E0, 9'h1F0, 9'h000, 9'h007, 9'h000, 9'h000, 9'h000};
    assign modes = {multiply_sign_select, multiply_integer_mode, acc_a_saturation_enable,
        acc_b_saturation_enable, program_space_visibility, cpu_priority_level};
    cscr_regs i_cscr_regs (.alu_flags_in(5'h00), .alu_flags_we(1'b0), .digit_carry_in(1'b0),
        .core_priority_in(3'h0), .core_priority_we(1'b0), .*);
    cscr_core_model i_cscr_core_model (.*);
    // Clock and hang ceiling
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches = mismatches + 1;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge clock);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd_check(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clock);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd_check
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test
    // Main sequence
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd_check(AC, 16'h0020);
        rd_check(AS, 16'h0000);
        check({15'h0, user_irq_enable}, 16'h0001);
        for (int i = 0; i < 8; i++) begin
            wr(r_a[i], r_w[i]);
            rd_check(r_a[i], r_r[i]);
            check({7'h0, modes}, {7'h0, r_o[i]});
        end
        // Remaining control outputs
        wr(AC, 16'h0032);
        #1;
        check({13'h0, data_write_saturation_enable, super_saturation_mode, rounding_mode},
            16'h0007);
        // Locked priority bits ignore writes
        nesting_disable_control <= 1'b1;
        wr(AS, 16'h00A0);
        rd_check(AS, 16'h0000);
        nesting_disable_control <= 1'b0;
        // Loop running, early exit mid-loop
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        repeat (2) @(posedge clock);
        rd_check(AS, 16'h0200);
        wr(AC, 16'h0800);
        #1;
        check({15'h0, loop_terminate_req}, 16'h0001);
        rd_check(AC, 16'h0300);
        for (int k = 0; k < 8 && loop_running; k++) @(posedge clock);
        check({15'h0, loop_running}, 16'h0000);
        rd_check(AS, 16'h0000);
        rd_check(AC, 16'h0000);
        rd_check(AE, 16'h0010);
        check({15'h0, irq}, 16'h0001);
        wr(AE, 16'h0010);
        rd_check(AE, 16'h0000);
        // Sticky saturation, combined clear, overflow, masking
        sat_cmd <= 2'h3;
        @(posedge clock);
        sat_cmd <= 2'h0;
        repeat (3) @(posedge clock);
        rd_check(AS, 16'h3400);
        rd_check(AS, 16'h3400);
        wr(AS, 16'h3000);
        rd_check(AS, 16'h0000);
        ovf_cmd <= 2'h3;
        repeat (3) @(posedge clock);
        rd_check(AS, 16'hC800);
        rd_check(AE, 16'h000F);
        check({15'h0, irq}, 16'h0001);
        wr(AM, 16'h0000);
        @(posedge clock);
        #1;
        check({15'h0, irq}, 16'h0000);
        wr(AM, 16'h001F);
        wr(AE, 16'h001F);
        rd_check(AE, 16'h0000);
        check({15'h0, irq}, 16'h0000);
        ovf_cmd <= 2'h0;
        // Reset in mid-run restores control defaults
        wr(AC, 16'h1004);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        rd_check(AC, 16'h0020);
        check({15'h0, data_write_saturation_enable}, 16'h0001);
        end_of_test();
    end
endmodule : testbench
